// >>> logic/rfc_field_extract.sv
module rfc_field_extract
    import rfc_pkg::*;
#(
    parameter int IR_W = 16
) (
    // instruction register side
    rfc_ctl_if.fx fif
);
    logic [3:0] cand [8];

    // window n picks bits n+3..n
    for (genvar n = 0; n < 8; n++) begin : g_win
        assign cand[n] = fif.instr_reg[n+3:n];
    end

    // top bit forced low unless mask bit set
    assign fif.field = {fif.top_bit_mask & cand[fif.test_select_field][3],
                        cand[fif.test_select_field][2:0]};
endmodule

// >>> logic/rfc_stall_ctrl.sv
`include "rfc_params.svh"

module rfc_stall_ctrl
    import rfc_pkg::*;
(
    // wait conditions
    rfc_ctl_if.st sif
);
    logic plain;
    logic mem_wait;
    logic io_wait;
    logic io_clash;

    assign plain = (sif.sequence_field == `RFC_SEQ_PLAIN);
    assign mem_wait = plain && (sif.memory_control_code == `RFC_MCC_MEM_WAIT)
                      && sif.mem_busy;
    assign io_wait = plain && (sif.memory_control_code == `RFC_MCC_IO_WAIT)
                     && !sif.io_done_status;
    assign io_clash = sif.io_request && sif.io_busy;
    assign sif.stall = mem_wait || io_wait || io_clash;
endmodule

// >>> logic/rfc_top.sv
// Functional notes
// - ALU operand inputs are sampled at the middle of each microcycle.
// - Next address, memory address and most updates happen at cycle end.
// - Function codes 100/111 bump the counter mid-cycle; ALU sees old value.
// - Byte flag changes mid-cycle so a same-cycle write uses the new flag.
// - Sequence 00, memory code 0001 waits until the memory cycle completes.
// - A new I/O request while I/O is busy suspends execution until idle.
// - Sequence 00, memory code 0010 waits until I/O done is true.
// - Selector 00 with mask 0 copies both specifiers from the microinstruction.
// - Sequence 00, selector 01 loads the extracted field into source, holds dest.
// - Sequence 00, selector 10 loads the extracted field into dest, holds source.
// - Test-select value n picks instruction bits n+3 down to n.
// - Mask 0 clears the extracted field's top bit; mask 1 passes it.
// - Sequence 00, selector 11 holds both specifiers.
// - Selector 00 with mask 1 holds dest and forces source by a condition.
// - Condition select 1: source becomes 1111 if operand bit 1 set, else 1110.
// - Condition select 0: source becomes 1111 if ALU bit 15 set, else 1110.
// - Field extraction runs alongside next-address formation in one cycle.
// - Any I/O request suppresses all specifier updates.
//
// Implementation choices: the plain strobed port and the register addresses.
`include "rfc_params.svh"

module rfc_top
    import rfc_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int CSA_W = 9
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // current microinstruction fields
    input wire logic [1:0] sequence_field,
    input wire logic [3:0] memory_control_code,
    input wire logic [1:0] field_load_selector,
    input wire logic top_bit_mask,
    input wire logic [2:0] test_select_field,
    input wire logic force_condition_select,
    input wire logic [2:0] register_function_code,
    input wire logic [3:0] uinst_dest_spec,
    input wire logic [3:0] uinst_src_spec,
    input wire logic [CSA_W-1:0] next_addr,
    input wire logic alu_a_from_pc,
    input wire logic mem_addr_from_pc,
    input wire logic byte_flag_set,
    input wire logic byte_flag_clr,
    // datapath status
    input wire logic [DATA_W-1:0] instr_reg,
    input wire logic [DATA_W-1:0] operand_reg,
    input wire logic [DATA_W-1:0] alu_result,
    input wire logic [DATA_W-1:0] alu_a_bus,
    input wire logic [DATA_W-1:0] alu_b_bus,
    input wire logic [DATA_W-1:0] mem_addr_bus,
    // memory and i/o handshakes
    input wire logic mem_busy,
    input wire logic io_request,
    input wire logic io_busy,
    input wire logic io_done_status,
    // control buffer specifiers
    output logic [3:0] dest_reg_specifier,
    output logic [3:0] src_reg_specifier,
    // datapath controls
    output logic [DATA_W-1:0] alu_a_latched,
    output logic [DATA_W-1:0] alu_b_latched,
    output logic [DATA_W-1:0] pc_value,
    output logic byte_flag,
    output logic [DATA_W-1:0] mem_addr,
    output logic mem_byte_sel,
    output logic [CSA_W-1:0] cs_addr,
    // cycle timing
    output logic mid_strobe,
    output logic uinst_advance,
    output logic stall_active,
    output logic io_start
);
    rfc_ctl_if #(.IR_W(DATA_W)) cif ();

    rfc_phase_t phase_q;
    logic run_q;
    logic mid_edge;
    logic end_edge;
    logic pc_inc;
    logic pc_wr;
    logic plain;
    logic force_bit;
    logic [3:0] force_val;
    logic [3:0] dest_q;
    logic [3:0] src_q;
    logic [DATA_W-1:0] alu_a_q;
    logic [DATA_W-1:0] alu_b_q;
    logic [DATA_W-1:0] pc_q;
    logic [DATA_W-1:0] pc_d;
    logic byte_flag_q;
    logic [DATA_W-1:0] mem_addr_q;
    logic mem_byte_sel_q;
    logic [CSA_W-1:0] cs_addr_q;
    logic mid_q;
    logic adv_q;
    logic stall_q;
    logic io_start_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    assign cif.instr_reg = instr_reg;
    assign cif.test_select_field = test_select_field;
    assign cif.top_bit_mask = top_bit_mask;
    assign cif.sequence_field = sequence_field;
    assign cif.memory_control_code = memory_control_code;
    assign cif.mem_busy = mem_busy;
    assign cif.io_request = io_request;
    assign cif.io_busy = io_busy;
    assign cif.io_done_status = io_done_status;

    rfc_field_extract #(
        .IR_W(DATA_W)
    ) u_extract (
        .fif(cif.fx)
    );

    rfc_stall_ctrl u_stall (
        .sif(cif.st)
    );

    // microcycle phases: first half ends at the mid edge, second at the end edge
    assign mid_edge = (phase_q == RFC_PH_FIRST) && run_q;
    assign end_edge = (phase_q == RFC_PH_SECOND) && !cif.stall;
    assign plain = (sequence_field == `RFC_SEQ_PLAIN);
    assign pc_inc = (register_function_code == `RFC_RFN_PC_INC_A)
                    || (register_function_code == `RFC_RFN_PC_INC_B);
    assign pc_wr = reg_wr && (reg_addr == `RFC_OFS_PC);
    assign force_bit = force_condition_select ? operand_reg[1] : alu_result[15];
    assign force_val = force_bit ? `RFC_FORCE_HI : `RFC_FORCE_LO;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_q <= RFC_PH_FIRST;
        end else begin
            case (phase_q)
                RFC_PH_FIRST: begin
                    if (run_q) begin
                        phase_q <= RFC_PH_SECOND;
                    end
                end
                RFC_PH_SECOND: begin
                    if (!cif.stall) begin
                        phase_q <= RFC_PH_FIRST;
                    end
                end
                default: begin
                    phase_q <= RFC_PH_FIRST;
                end
            endcase
        end
    end

    // run bit lets software halt at a cycle boundary
    always_ff @(posedge core_clk) begin
        if (reset) begin
            run_q <= `RFC_CTRL_RUN_RST;
        end else if (reg_wr && (reg_addr == `RFC_OFS_CTRL)) begin
            run_q <= reg_wdata[`RFC_CTRL_RUN_BIT];
        end
    end

    // operands latched once per cycle, held through any stall
    always_ff @(posedge core_clk) begin
        if (reset) begin
            alu_a_q <= '0;
            alu_b_q <= '0;
        end else if (mid_edge) begin
            alu_a_q <= alu_a_from_pc ? pc_q : alu_a_bus;
            alu_b_q <= alu_b_bus;
        end
    end

    always_comb begin
        pc_d = pc_q;
        if (pc_wr) begin
            pc_d = reg_wdata;
        end else if (mid_edge && pc_inc) begin
            pc_d = pc_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_q <= `RFC_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // set wins over clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            byte_flag_q <= 1'b0;
        end else if (mid_edge) begin
            if (byte_flag_set) begin
                byte_flag_q <= 1'b1;
            end else if (byte_flag_clr) begin
                byte_flag_q <= 1'b0;
            end
        end
    end

    // end-of-cycle updates; counter and byte flag already carry mid-cycle values
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_addr_q <= '0;
            mem_byte_sel_q <= 1'b0;
            cs_addr_q <= `RFC_CSA_RST;
        end else if (end_edge) begin
            mem_addr_q <= mem_addr_from_pc ? pc_q : mem_addr_bus;
            mem_byte_sel_q <= byte_flag_q;
            cs_addr_q <= next_addr;
        end
    end

    // control buffer specifiers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dest_q <= `RFC_SPEC_RST;
            src_q <= `RFC_SPEC_RST;
        end else if (end_edge && !io_request) begin
            case (field_load_selector)
                RFC_FLS_MICRO: begin
                    if (!top_bit_mask) begin
                        dest_q <= uinst_dest_spec;
                        src_q <= uinst_src_spec;
                    end else begin
                        src_q <= force_val;
                    end
                end
                RFC_FLS_TO_SRC: begin
                    if (plain) begin
                        src_q <= cif.field;
                    end
                end
                RFC_FLS_TO_DEST: begin
                    if (plain) begin
                        dest_q <= cif.field;
                    end
                end
                RFC_FLS_HOLD: begin
                    dest_q <= dest_q;
                end
                default: begin
                    dest_q <= dest_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mid_q <= 1'b0;
            adv_q <= 1'b0;
            stall_q <= 1'b0;
            io_start_q <= 1'b0;
        end else begin
            mid_q <= mid_edge;
            adv_q <= end_edge;
            stall_q <= (phase_q == RFC_PH_SECOND) && cif.stall;
            io_start_q <= end_edge && io_request;
        end
    end

    always_comb begin
        rdata_d = '0;
        case (reg_addr)
            `RFC_OFS_CTRL: rdata_d[`RFC_CTRL_RUN_BIT] = run_q;
            `RFC_OFS_PC: rdata_d = pc_q;
            `RFC_OFS_STATUS: begin
                rdata_d[`RFC_STAT_PHASE_BIT] = phase_q;
                rdata_d[`RFC_STAT_STALL_BIT] = stall_q;
                rdata_d[`RFC_STAT_BYTE_BIT] = byte_flag_q;
            end
            `RFC_OFS_SPEC: rdata_d[7:0] = {src_q, dest_q};
            default: rdata_d = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rdata_d : '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign dest_reg_specifier = dest_q;
    assign src_reg_specifier = src_q;
    assign alu_a_latched = alu_a_q;
    assign alu_b_latched = alu_b_q;
    assign pc_value = pc_q;
    assign byte_flag = byte_flag_q;
    assign mem_addr = mem_addr_q;
    assign mem_byte_sel = mem_byte_sel_q;
    assign cs_addr = cs_addr_q;
    assign mid_strobe = mid_q;
    assign uinst_advance = adv_q;
    assign stall_active = stall_q;
    assign io_start = io_start_q;

    // checks
    logic opnd_bit1;
    logic alu_bit15;
    logic [3:0] exp_field;
    logic [DATA_W-1:0] ir_shift;

    assign opnd_bit1 = operand_reg[1];
    assign alu_bit15 = alu_result[15];
    assign ir_shift = instr_reg >> test_select_field;
    assign exp_field = {top_bit_mask & ir_shift[3], ir_shift[2:0]};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_ALU_MID_SAMPLE: assert property (
        mid_edge && !alu_a_from_pc |=> alu_a_q == $past(alu_a_bus) && alu_b_q == $past(alu_b_bus)
    ) else $error("alu operands not sampled at mid-cycle");

    AST_ALU_HOLD: assert property (
        !mid_edge |=> $stable(alu_b_q) && $stable(alu_a_q)
    ) else $error("alu operands changed outside mid-cycle");

    AST_END_ADDR: assert property (
        end_edge |=> cs_addr_q == $past(next_addr) && uinst_advance
    ) else $error("next address not applied at cycle end");

    AST_PC_INC_MID: assert property (
        mid_edge && pc_inc && !pc_wr |=> pc_q == $past(pc_q) + 16'h0001
    ) else $error("counter not incremented at mid-cycle");

    AST_PC_OLD_TO_ALU: assert property (
        mid_edge && alu_a_from_pc |=> alu_a_q == $past(pc_q)
    ) else $error("alu did not get old counter value");

    AST_BYTE_SAME_CYCLE: assert property (
        mid_edge && byte_flag_set ##1 end_edge |=> mem_byte_sel_q
    ) else $error("byte select missed mid-cycle flag");

    AST_MEM_WAIT: assert property (
        phase_q == RFC_PH_SECOND && plain && memory_control_code == `RFC_MCC_MEM_WAIT
        && mem_busy |=> phase_q == RFC_PH_SECOND && !uinst_advance
    ) else $error("advanced during memory wait");

    AST_IO_BUSY: assert property (
        phase_q == RFC_PH_SECOND && io_request && io_busy |=> stall_active && !io_start
    ) else $error("advanced while i/o busy");

    AST_IO_DONE_WAIT: assert property (
        phase_q == RFC_PH_SECOND && plain && memory_control_code == `RFC_MCC_IO_WAIT
        && !io_done_status |-> !end_edge
    ) else $error("advanced before i/o done");

    AST_NORMAL_LOAD: assert property (
        end_edge && !io_request && field_load_selector == RFC_FLS_MICRO && !top_bit_mask
        |=> dest_q == $past(uinst_dest_spec) && src_q == $past(uinst_src_spec)
    ) else $error("normal specifier load failed");

    AST_EXTRACT_SRC: assert property (
        end_edge && !io_request && plain && field_load_selector == RFC_FLS_TO_SRC
        |=> src_q == $past(exp_field) && $stable(dest_q)
    ) else $error("source specifier extraction wrong");

    AST_EXTRACT_DEST: assert property (
        end_edge && !io_request && plain && field_load_selector == RFC_FLS_TO_DEST
        |=> dest_q == $past(exp_field) && $stable(src_q)
    ) else $error("dest specifier extraction wrong");

    AST_HOLD_BOTH: assert property (
        end_edge && plain && field_load_selector == RFC_FLS_HOLD
        |=> $stable(dest_q) && $stable(src_q)
    ) else $error("specifiers changed in hold mode");

    AST_FORCE_OPND: assert property (
        end_edge && !io_request && field_load_selector == RFC_FLS_MICRO && top_bit_mask
        && force_condition_select |=> src_q == ($past(opnd_bit1) ? 4'hF : 4'hE)
        && $stable(dest_q)
    ) else $error("forced source from operand bit wrong");

    AST_FORCE_ALU: assert property (
        end_edge && !io_request && field_load_selector == RFC_FLS_MICRO && top_bit_mask
        && !force_condition_select |=> src_q == ($past(alu_bit15) ? 4'hF : 4'hE)
    ) else $error("forced source from alu bit wrong");

    AST_IO_SUPPRESS: assert property (
        io_request |=> $stable(dest_q) && $stable(src_q)
    ) else $error("specifiers changed during i/o request");
endmodule

// >>> shared/rfc_ctl_if.sv
interface rfc_ctl_if #(
    parameter int IR_W = 16
);
    logic [IR_W-1:0] instr_reg;
    logic [2:0] test_select_field;
    logic top_bit_mask;
    logic [3:0] field;
    logic [1:0] sequence_field;
    logic [3:0] memory_control_code;
    logic mem_busy;
    logic io_request;
    logic io_busy;
    logic io_done_status;
    logic stall;

    modport ctl (
        output instr_reg, test_select_field, top_bit_mask,
        output sequence_field, memory_control_code, mem_busy,
        output io_request, io_busy, io_done_status,
        input field, stall
    );
    modport fx (
        input instr_reg, test_select_field, top_bit_mask,
        output field
    );
    modport st (
        input sequence_field, memory_control_code, mem_busy,
        input io_request, io_busy, io_done_status,
        output stall
    );
endinterface

// >>> shared/rfc_params.svh
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

// register port offsets
`define RFC_OFS_CTRL 4'h0
`define RFC_OFS_PC 4'h4
`define RFC_OFS_STATUS 4'h8
`define RFC_OFS_SPEC 4'hC

// field positions
`define RFC_CTRL_RUN_BIT 0
`define RFC_STAT_PHASE_BIT 0
`define RFC_STAT_STALL_BIT 1
`define RFC_STAT_BYTE_BIT 2

// reset values
`define RFC_CTRL_RUN_RST 1'h1
`define RFC_PC_RST 16'h0000
`define RFC_SPEC_RST 4'h0
`define RFC_CSA_RST 9'h000

// microinstruction codes
`define RFC_SEQ_PLAIN 2'h0
`define RFC_MCC_MEM_WAIT 4'h1
`define RFC_MCC_IO_WAIT 4'h2
`define RFC_RFN_PC_INC_A 3'h4
`define RFC_RFN_PC_INC_B 3'h7
`define RFC_FORCE_HI 4'hF
`define RFC_FORCE_LO 4'hE

// timing: mid-cycle sampling after this many core clocks of the first half
`define RFC_HALF_CYCLES 1

`endif

// >>> shared/rfc_pkg.sv
package rfc_pkg;

    typedef enum logic [0:0] {
        RFC_PH_FIRST = 1'b0,
        RFC_PH_SECOND = 1'b1
    } rfc_phase_t;

    typedef enum logic [1:0] {
        RFC_FLS_MICRO = 2'b00,
        RFC_FLS_TO_SRC = 2'b01,
        RFC_FLS_TO_DEST = 2'b10,
        RFC_FLS_HOLD = 2'b11
    } rfc_fls_t;

endpackage

// >>> verif/rfc_mem_io_model.sv
module rfc_mem_io_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // start of a memory cycle or an i/o operation
    input wire logic mem_go,
    input wire logic io_go,
    input wire logic [3:0] busy_len,
    // status seen by the block
    output logic mem_busy,
    output logic io_busy,
    output logic io_done_status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mem_cnt_q;
    logic [3:0] io_cnt_q;

    // busy for busy_len clocks after the start is seen; zero answers at once
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_cnt_q <= 4'h0;
        end else if (mem_go) begin
            mem_cnt_q <= busy_len;
        end else if (mem_cnt_q != 4'h0) begin
            mem_cnt_q <= mem_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_cnt_q <= 4'h0;
        end else if (io_go) begin
            io_cnt_q <= busy_len;
        end else if (io_cnt_q != 4'h0) begin
            io_cnt_q <= io_cnt_q - 4'h1;
        end
    end

    assign mem_busy = (mem_cnt_q != 4'h0);
    assign io_busy = (io_cnt_q != 4'h0);
    assign io_done_status = (io_cnt_q == 4'h0);
endmodule

// >>> verif/test_register_field_control.sv
`include "rfc_params.svh"

module test_register_field_control;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] sl;
        logic [1:0] sq;
        logic [3:0] mc;
        logic mk;
        logic [2:0] ts;
        logic wf;
        logic [2:0] rf;
        logic [3:0] ds;
        logic [3:0] ss;
        logic [8:0] na;
        logic apc;
        logic mpc;
        logic bs;
        logic bc;
        logic ioq;
    } rfc_tb_ctl_t;
    typedef struct packed {
        logic [15:0] ir;
        logic [15:0] op;
        logic [15:0] alu;
        logic [15:0] ab;
        logic [15:0] bb;
        logic [15:0] ma;
    } rfc_tb_dp_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    rfc_tb_ctl_t c = '{sl: 2'h3, default: '0};
    rfc_tb_ctl_t st;
    rfc_tb_dp_t d = '0;
    rfc_tb_dp_t sd;
    logic go_mem = 1'b0;
    logic go_io = 1'b0;
    logic [3:0] busy_len = 4'h0;
    wire logic mem_busy, io_busy, io_done_status;
    logic [15:0] reg_rdata, alu_a_latched, alu_b_latched, pc_value, mem_addr;
    logic [15:0] m_alua, m_alub, m_pc;
    logic [3:0] dest_reg_specifier, src_reg_specifier, exp_dest, exp_src;
    logic [8:0] cs_addr, m_cs;
    logic byte_flag, mem_byte_sel, mid_strobe, uinst_advance, stall_active, io_start, m_byte;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    rfc_top uut (
        .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sequence_field(c.sq), .memory_control_code(c.mc), .field_load_selector(c.sl),
        .top_bit_mask(c.mk), .test_select_field(c.ts), .force_condition_select(c.wf),
        .register_function_code(c.rf), .uinst_dest_spec(c.ds), .uinst_src_spec(c.ss),
        .next_addr(c.na), .alu_a_from_pc(c.apc), .mem_addr_from_pc(c.mpc),
        .byte_flag_set(c.bs), .byte_flag_clr(c.bc), .instr_reg(d.ir), .operand_reg(d.op),
        .alu_result(d.alu), .alu_a_bus(d.ab), .alu_b_bus(d.bb), .mem_addr_bus(d.ma),
        .mem_busy, .io_request(c.ioq), .io_busy, .io_done_status,
        .dest_reg_specifier, .src_reg_specifier, .alu_a_latched, .alu_b_latched,
        .pc_value, .byte_flag, .mem_addr, .mem_byte_sel, .cs_addr,
        .mid_strobe, .uinst_advance, .stall_active, .io_start
    );
    rfc_mem_io_model far_end (
        .core_clk, .reset, .mem_go(go_mem), .io_go(go_io), .busy_len,
        .mem_busy, .io_busy, .io_done_status
    );

    always #50 core_clk = ~core_clk;

    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask

    // one microinstruction from st/sd, n stalled edges, partner busy for len
    task automatic ex(input int n, input int len, input logic [1:0] go);
        int k = 0;
        while (mid_strobe !== 1'b1 && k < 8) begin
            @(negedge core_clk);
            k++;
        end
        @(posedge core_clk);
        c <= st;
        d <= sd;
        go_mem <= go[0];
        go_io <= go[1];
        busy_len <= len[3:0];
        @(posedge core_clk);
        go_mem <= 1'b0;
        go_io <= 1'b0;
        d.bb <= ~sd.bb;
        @(negedge core_clk);
        chk(mid_strobe, 1'b1);
        m_alua = alu_a_latched;
        m_alub = alu_b_latched;
        m_pc = pc_value;
        m_byte = byte_flag;
        m_cs = cs_addr;
        repeat (n) begin
            @(posedge core_clk);
            @(negedge core_clk);
            chk({uinst_advance, stall_active}, 2'b01);
        end
        @(posedge core_clk);
        // datapath left as is, so alu data stays for the next instruction too
        c <= '{sl: 2'h3, default: '0};
        @(negedge core_clk);
        chk(uinst_advance, 1'b1);
    endtask

    task automatic t_reset();
        chk({dest_reg_specifier, src_reg_specifier, pc_value}, 24'h0);
        reg_check(`RFC_OFS_CTRL, 16'h0001);
        reg_check(4'h2, 16'h0000);
        reg_write(`RFC_OFS_SPEC, 16'h00FF);
        reg_check(`RFC_OFS_SPEC, 16'h0000);
    endtask

    task automatic t_copy();
        st = '{sl: 2'h0, ds: 4'h5, ss: 4'hA, na: 9'h1A5, default: '0};
        sd = '{ab: 16'hC0DE, bb: 16'h1234, ma: 16'h2468, default: '0};
        ex(0, 0, 2'b00);
        chk(m_alua, 16'hC0DE);
        chk(m_alub, 16'h1234);
        chk(m_cs, 9'h000);
        chk({cs_addr, mem_addr}, {9'h1A5, 16'h2468});
        chk({dest_reg_specifier, src_reg_specifier}, 8'h5A);
        chk({alu_a_latched, alu_b_latched}, 32'hC0DE_1234);
        exp_dest = 4'h5;
        exp_src = 4'hA;
        reg_check(`RFC_OFS_SPEC, 16'h00A5);
    endtask

    task automatic t_extract();
        logic [3:0] f;
        sd = '{ir: 16'h0DB6, default: '0};
        for (int s = 1; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                for (int t = 0; t < 8; t++) begin
                    st = '{sl: s[1:0], mk: m[0], ts: t[2:0], ds: 4'h9, ss: 4'h9,
                        na: {s[1:0], m[0], 3'h0, t[2:0]}, default: '0};
                    ex(0, 0, 2'b00);
                    f = 4'(16'h0DB6 >> t);
                    f[3] = f[3] & m[0];
                    if (s == 1) exp_src = f;
                    if (s == 2) exp_dest = f;
                    chk(cs_addr, st.na);
                    chk(dest_reg_specifier, exp_dest);
                    chk(src_reg_specifier, exp_src);
                end
            end
        end
        st = '{sl: 2'h1, sq: 2'h1, ts: 3'h4, default: '0};
        ex(0, 0, 2'b00);
        chk({dest_reg_specifier, src_reg_specifier}, {exp_dest, exp_src});
    endtask

    task automatic t_force();
        for (int w = 0; w < 2; w++) begin
            for (int b = 0; b < 2; b++) begin
                st = '{mk: 1'b1, wf: w[0], ds: 4'h3, ss: 4'h3, default: '0};
                sd = '{op: {14'h0, b[0] ^ ~w[0], 1'b0}, alu: {b[0] ^ w[0], 15'h0}, default: '0};
                ex(0, 0, 2'b00);
                exp_src = b[0] ? 4'hF : 4'hE;
                chk(dest_reg_specifier, exp_dest);
                chk(src_reg_specifier, exp_src);
            end
        end
        reg_check(`RFC_OFS_SPEC, {8'h00, exp_src, exp_dest});
    endtask

    task automatic t_io();
        for (int s = 0; s < 5; s++) begin
            st = '{sl: s[1:0], mk: s[0] | s[2], ioq: 1'b1, ds: 4'h1, ss: 4'h2, default: '0};
            sd = '{ir: 16'hFFFF, alu: 16'h8000, op: 16'hFFFF, default: '0};
            if (s == 3) ex(2, 2, 2'b10);
            else ex(0, 0, 2'b00);
            chk(io_start, 1'b1);
            chk({dest_reg_specifier, src_reg_specifier}, {exp_dest, exp_src});
        end
    endtask

    task automatic t_wait();
        st = '{mc: 4'h1, sl: 2'h3, default: '0};
        ex(3, 3, 2'b01);
        st = '{mc: 4'h2, sl: 2'h3, default: '0};
        ex(4, 4, 2'b10);
        st = '{sq: 2'h1, mc: 4'h1, sl: 2'h3, default: '0};
        ex(0, 3, 2'b01);
        st = '{sq: 2'h1, mc: 4'h2, sl: 2'h3, default: '0};
        ex(0, 3, 2'b10);
    endtask

    task automatic t_pc();
        logic [15:0] p;
        p = 16'hFFFE;
        reg_write(`RFC_OFS_PC, p);
        for (int r = 0; r < 8; r++) begin
            st = '{rf: r[2:0], apc: 1'b1, mpc: 1'b1, bs: r[0], bc: ~r[0], sl: 2'h3, default: '0};
            sd = '{ab: 16'h5555, ma: 16'h3333, default: '0};
            ex(0, 0, 2'b00);
            chk(m_alua, p);
            if (r == 4 || r == 7) p = p + 16'h0001;
            chk(m_pc, p);
            chk(mem_addr, p);
            chk({m_byte, mem_byte_sel}, {2{r[0]}});
        end
        reg_check(`RFC_OFS_PC, p);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_copy();
        t_extract();
        t_force();
        t_io();
        t_wait();
        t_pc();
        test_done();
    end
endmodule
